// ===== design/pxc_pkg.sv
// constants and types of the expander
package pxc_pkg;

   // ----------------------------------------------------------------
   // select pin classes and address layout
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PXC_SEL_GND,
      PXC_SEL_SUP,
      PXC_SEL_SCL,
      PXC_SEL_SDA
   } pxc_sel_type;

   localparam logic [2:0] PXC_ADDR_FIXED = 3'h6;  // top bits 1,1,0
   localparam int PXC_NPORTS = 8;
   localparam logic [1:0] PXC_INIT_WAIT = 2'h3;   // strap settle cycles
   localparam logic [3:0] PXC_BITS_BYTE = 4'h8;

   // ----------------------------------------------------------------
   // apb register map
   // ----------------------------------------------------------------
   localparam logic [7:0] PXC_OFS_CTRL = 8'h00;
   localparam logic [7:0] PXC_OFS_STATUS = 8'h04;
   localparam logic [7:0] PXC_OFS_MASK = 8'h08;
   localparam logic [7:0] PXC_OFS_FLAGS = 8'h0C;
   localparam logic [7:0] PXC_OFS_PORTS = 8'h10;
   localparam logic [7:0] PXC_OFS_OUTPUT = 8'h14;
   localparam logic [7:0] PXC_OFS_ADDR = 8'h18;

   // status / mask bit positions
   localparam int PXC_EV_CHANGE = 0;
   localparam int PXC_EV_ACCESS = 1;
   localparam int PXC_EV_WRITE = 2;
   localparam int PXC_NEVENTS = 3;

   // reset values
   localparam logic PXC_CTRL_RST = 1'b1;
   localparam logic [2:0] PXC_MASK_RST = 3'h0;
   localparam logic [7:0] PXC_OUT_RST = 8'hFF;

   // ----------------------------------------------------------------
   // two address bits from one pin class
   // ----------------------------------------------------------------
   function automatic logic [1:0] pxc_addr_bits(pxc_sel_type cls,
                                                logic upper);
      logic [1:0] bits;
      bits = 2'h0;
      if (upper) begin
         case (cls)
            PXC_SEL_SCL: bits = 2'h0;
            PXC_SEL_SDA: bits = 2'h1;
            PXC_SEL_GND: bits = 2'h2;
            default: bits = 2'h3;
         endcase
      end else begin
         case (cls)
            PXC_SEL_GND: bits = 2'h0;
            PXC_SEL_SUP: bits = 2'h1;
            PXC_SEL_SCL: bits = 2'h2;
            default: bits = 2'h3;
         endcase
      end
      return bits;
   endfunction

endpackage

// ===== design/pxc_sel_classify.sv
// four-level select pin classifier
`timescale 1ns/1ps
module pxc_sel_classify (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // synchronised levels
   input wire logic pin_s,
   input wire logic scl_s,
   input wire logic sda_s,
   // frame markers
   input wire logic busy,
   input wire logic frame_end,
   // result
   output pxc_pkg::pxc_sel_type cls_reg
);
   import pxc_pkg::*;

   logic [1:0] init_cnt_reg;
   logic saw_hi_reg;
   logic saw_lo_reg;
   logic ne_scl_reg;
   logic ne_sda_reg;

   // -----------------------------------------------------------------
   // observation during a frame
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         saw_hi_reg <= 1'b0;
         saw_lo_reg <= 1'b0;
         ne_scl_reg <= 1'b0;
         ne_sda_reg <= 1'b0;
      end else if (!busy) begin
         saw_hi_reg <= 1'b0;
         saw_lo_reg <= 1'b0;
         ne_scl_reg <= 1'b0;
         ne_sda_reg <= 1'b0;
      end else begin
         saw_hi_reg <= saw_hi_reg | pin_s;
         saw_lo_reg <= saw_lo_reg | ~pin_s;
         ne_scl_reg <= ne_scl_reg | (pin_s ^ scl_s);
         ne_sda_reg <= ne_sda_reg | (pin_s ^ sda_s);
      end
   end

   // -----------------------------------------------------------------
   // class: strap after reset, then at frame end
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_cnt_reg <= 2'h0;
         cls_reg <= PXC_SEL_SUP;
      end else if (init_cnt_reg != PXC_INIT_WAIT) begin
         init_cnt_reg <= init_cnt_reg + 2'h1;
         if (init_cnt_reg == PXC_INIT_WAIT - 2'h1) begin
            cls_reg <= pin_s ? PXC_SEL_SUP : PXC_SEL_GND;
         end
      end else if (frame_end) begin
         if (!saw_lo_reg) begin
            cls_reg <= PXC_SEL_SUP;
         end else if (!saw_hi_reg) begin
            cls_reg <= PXC_SEL_GND;
         end else if (!ne_scl_reg) begin
            cls_reg <= PXC_SEL_SCL;
         end else if (!ne_sda_reg) begin
            cls_reg <= PXC_SEL_SDA;
         end
      end
   end

endmodule // pxc_sel_classify

// ===== design/pxc_expander.sv
// port expander with change detect, serial and apb
`timescale 1ns/1ps
module pxc_expander (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // two-wire serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // address select pins
   input wire logic addr_select_high_group,
   input wire logic addr_select_low_group,
   // open-drain ports
   input wire logic [pxc_pkg::PXC_NPORTS-1:0] io_port_pins_in,
   output logic [pxc_pkg::PXC_NPORTS-1:0] io_port_pins_out,
   output logic [pxc_pkg::PXC_NPORTS-1:0] io_port_pins_oe,
   output logic [pxc_pkg::PXC_NPORTS-1:0] port_pullup_en,
   // change alert, open drain, active low
   output logic change_alert_n_out,
   output logic change_alert_n_oe
);
   import pxc_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_MACK,
      ST_IGNORE
   } pxc_bus_state_type;

   // -----------------------------------------------------------------
   // synchronisers
   // -----------------------------------------------------------------
   logic [1:0] scl_meta_reg;
   logic [1:0] sda_meta_reg;
   logic [1:0] selh_meta_reg;
   logic [1:0] sell_meta_reg;
   logic [PXC_NPORTS-1:0] port_meta_reg;
   logic [PXC_NPORTS-1:0] port_s_reg;
   logic scl_d_reg;
   logic sda_d_reg;

   // two flops per pin, one more for edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_meta_reg <= 2'h3;
         sda_meta_reg <= 2'h3;
         selh_meta_reg <= 2'h3;
         sell_meta_reg <= 2'h3;
         port_meta_reg <= '1;
         port_s_reg <= '1;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_meta_reg <= {scl_meta_reg[0], scl_in};
         sda_meta_reg <= {sda_meta_reg[0], sda_in};
         selh_meta_reg <= {selh_meta_reg[0], addr_select_high_group};
         sell_meta_reg <= {sell_meta_reg[0], addr_select_low_group};
         port_meta_reg <= io_port_pins_in;
         port_s_reg <= port_meta_reg;
         scl_d_reg <= scl_meta_reg[1];
         sda_d_reg <= sda_meta_reg[1];
      end
   end

   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   // bus conditions from synchronised levels
   assign scl_s = scl_meta_reg[1];
   assign sda_s = sda_meta_reg[1];
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   // -----------------------------------------------------------------
   // frame tracking for the select classifiers
   // -----------------------------------------------------------------
   logic frame_busy_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_busy_reg <= 1'b0;
      end else if (bus_start) begin
         frame_busy_reg <= 1'b1;
      end else if (bus_stop) begin
         frame_busy_reg <= 1'b0;
      end
   end

   pxc_sel_type cls_high;
   pxc_sel_type cls_low;

   pxc_sel_classify u_cls_high (
      .pclk(pclk),
      .presetn(presetn),
      .pin_s(selh_meta_reg[1]),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .busy(frame_busy_reg),
      .frame_end(bus_stop),
      .cls_reg(cls_high)
   );

   pxc_sel_classify u_cls_low (
      .pclk(pclk),
      .presetn(presetn),
      .pin_s(sell_meta_reg[1]),
      .scl_s(scl_s),
      .sda_s(sda_s),
      .busy(frame_busy_reg),
      .frame_end(bus_stop),
      .cls_reg(cls_low)
   );

   // -----------------------------------------------------------------
   // decoded address and pullups
   // -----------------------------------------------------------------
   logic [6:0] slave_addr;
   logic high_on;
   logic low_on;

   assign slave_addr = {PXC_ADDR_FIXED,
                        pxc_addr_bits(cls_high, 1'b1),
                        pxc_addr_bits(cls_low, 1'b0)};
   assign high_on = (cls_high != PXC_SEL_GND);
   assign low_on = (cls_low != PXC_SEL_GND);
   assign port_pullup_en = {{4{high_on}}, {4{low_on}}};

   // -----------------------------------------------------------------
   // serial slave state machine
   // -----------------------------------------------------------------
   pxc_bus_state_type state_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_cnt_reg;
   logic rw_reg;
   logic second_reg;
   logic read_active_reg;
   logic ctrl_en_reg;
   logic [PXC_NPORTS-1:0] snap_reg;
   logic [PXC_NPORTS-1:0] flags_reg;
   logic [PXC_NPORTS-1:0] flags_prev_reg;
   logic access_ev;
   logic write_ev;
   logic addr_hit;

   assign addr_hit = (shift_reg[7:1] == slave_addr) & ctrl_en_reg;
   // reload at address acknowledge, and at each new port byte of a read
   assign access_ev = ((state_reg == ST_ADDR_ACK) & scl_rise) |
                      ((state_reg == ST_MACK) & scl_fall & ~second_reg);
   assign write_ev = (state_reg == ST_RX) & scl_fall &
                     (bit_cnt_reg == PXC_BITS_BYTE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
         shift_reg <= 8'h00;
         bit_cnt_reg <= 4'h0;
         rw_reg <= 1'b0;
         second_reg <= 1'b0;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         state_reg <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (bus_start) begin
         state_reg <= ST_ADDR;
         bit_cnt_reg <= 4'h0;
         sda_oe <= 1'b0;
      end else begin
         case (state_reg)
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  shift_reg <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == PXC_BITS_BYTE) begin
                  bit_cnt_reg <= 4'h0;
                  if (state_reg == ST_RX) begin
                     state_reg <= ST_RX_ACK;
                     sda_oe <= 1'b1;
                  end else if (addr_hit) begin
                     state_reg <= ST_ADDR_ACK;
                     rw_reg <= shift_reg[0];
                     sda_oe <= 1'b1;
                  end else begin
                     state_reg <= ST_IGNORE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall && rw_reg) begin
                  state_reg <= ST_TX;
                  second_reg <= 1'b0;
                  shift_reg <= {snap_reg[6:0], 1'b1};
                  sda_oe <= ~snap_reg[7];
               end else if (scl_fall) begin
                  state_reg <= ST_RX;
                  sda_oe <= 1'b0;
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  state_reg <= ST_RX;
                  sda_oe <= 1'b0;
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == PXC_BITS_BYTE) begin
                  state_reg <= ST_MACK;
                  bit_cnt_reg <= 4'h0;
                  second_reg <= ~second_reg;
                  sda_oe <= 1'b0;
               end else if (scl_fall) begin
                  sda_oe <= ~shift_reg[7];
                  shift_reg <= {shift_reg[6:0], 1'b1};
               end
            end
            ST_MACK: begin
               if (scl_rise && sda_s) begin
                  state_reg <= ST_IGNORE; // master ended the read
               end else if (scl_fall && second_reg) begin
                  state_reg <= ST_TX;
                  shift_reg <= {flags_prev_reg[6:0], 1'b1};
                  sda_oe <= ~flags_prev_reg[7];
               end else if (scl_fall) begin
                  state_reg <= ST_TX;
                  shift_reg <= {port_s_reg[6:0], 1'b1};
                  sda_oe <= ~port_s_reg[7];
               end
            end
            default: begin
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   assign sda_out = 1'b0;

   // -----------------------------------------------------------------
   // snapshot, transition flags and change alert
   // -----------------------------------------------------------------
   logic [PXC_NPORTS-1:0] diff;

   assign diff = snap_reg ^ port_s_reg;

   // reload on access, from the levels it compares
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_reg <= '1;
         flags_reg <= '0;
         flags_prev_reg <= '0;
      end else if (access_ev) begin
         snap_reg <= port_s_reg;
         flags_prev_reg <= flags_reg | diff;
         flags_reg <= '0;
      end else begin
         flags_reg <= flags_reg | diff;
      end
   end

   // alert held off in a read frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_active_reg <= 1'b0;
      end else if (bus_stop || bus_start) begin
         read_active_reg <= 1'b0;
      end else if (access_ev && rw_reg) begin
         read_active_reg <= 1'b1;
      end
   end

   assign change_alert_n_out = 1'b0;
   assign change_alert_n_oe = (|flags_reg) & ~read_active_reg;

   // -----------------------------------------------------------------
   // port output latch
   // -----------------------------------------------------------------
   logic [PXC_NPORTS-1:0] out_reg;
   logic [1:0] pwr_cnt_reg;
   logic apb_wr;
   logic apb_rd;

   assign apb_wr = psel & penable & pwrite;
   assign apb_rd = psel & ~penable & ~pwrite;

   // defaults applied once the strap levels are caught
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_cnt_reg <= 2'h0;
         out_reg <= PXC_OUT_RST;
      end else if (pwr_cnt_reg != PXC_INIT_WAIT) begin
         pwr_cnt_reg <= pwr_cnt_reg + 2'h1;
         out_reg <= {{4{selh_meta_reg[1]}}, {4{sell_meta_reg[1]}}};
      end else if (write_ev) begin
         out_reg <= shift_reg;
      end else if (apb_wr && paddr == PXC_OFS_OUTPUT) begin
         out_reg <= pwdata[7:0];
      end
   end

   assign io_port_pins_out = '0;
   assign io_port_pins_oe = ~out_reg;

   // -----------------------------------------------------------------
   // apb registers and interrupt
   // -----------------------------------------------------------------
   logic [PXC_NEVENTS-1:0] status_reg;
   logic [PXC_NEVENTS-1:0] mask_reg;
   logic [PXC_NEVENTS-1:0] ev_set;
   logic [PXC_NEVENTS-1:0] stat_taken;
   logic mapped;

   assign ev_set[PXC_EV_CHANGE] = |(diff & ~flags_reg);
   assign ev_set[PXC_EV_ACCESS] = access_ev;
   assign ev_set[PXC_EV_WRITE] = write_ev;

   // control and mask writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_en_reg <= PXC_CTRL_RST;
         mask_reg <= PXC_MASK_RST;
      end else if (apb_wr && paddr == PXC_OFS_CTRL) begin
         ctrl_en_reg <= pwdata[0];
      end else if (apb_wr && paddr == PXC_OFS_MASK) begin
         mask_reg <= pwdata[PXC_NEVENTS-1:0];
      end
   end

   // read clears returned bits; new events win
   assign stat_taken = (psel && penable && !pwrite &&
                        paddr == PXC_OFS_STATUS) ?
                       prdata[PXC_NEVENTS-1:0] : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= '0;
      end else begin
         status_reg <= (status_reg & ~stat_taken) | ev_set;
      end
   end

   assign irq = |(status_reg & mask_reg);

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd) begin
         case (paddr)
            PXC_OFS_CTRL: prdata <= {31'h0000_0000, ctrl_en_reg};
            PXC_OFS_STATUS: prdata <= {29'h0000_0000, status_reg};
            PXC_OFS_MASK: prdata <= {29'h0000_0000, mask_reg};
            PXC_OFS_FLAGS: prdata <= {24'h00_0000, flags_reg};
            PXC_OFS_PORTS: prdata <= {16'h0000, snap_reg, port_s_reg};
            PXC_OFS_OUTPUT: prdata <= {24'h00_0000, out_reg};
            PXC_OFS_ADDR: prdata <= {8'h00, port_pullup_en, 4'h0,
                                     cls_high, cls_low, 1'b0, slave_addr};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign mapped = (paddr == PXC_OFS_CTRL) | (paddr == PXC_OFS_STATUS) |
                   (paddr == PXC_OFS_MASK) | (paddr == PXC_OFS_FLAGS) |
                   (paddr == PXC_OFS_PORTS) | (paddr == PXC_OFS_OUTPUT) |
                   (paddr == PXC_OFS_ADDR);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

endmodule // pxc_expander

// ===== verif/pxc_expander_chk.sv
// checks on expander pins
`timescale 1ns/1ps
module pxc_expander_chk (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   // ports, alert and interrupt
   input wire logic [7:0] io_port_pins_in,
   input wire logic [7:0] io_port_pins_oe,
   input wire logic [7:0] port_pullup_en,
   input wire logic change_alert_n_out,
   input wire logic change_alert_n_oe,
   input wire logic irq
);
   // ------------------
   // helper state
   // ------------------
   logic scl_prev_reg, sda_prev_reg, in_frame_reg;
   logic [3:0] age_reg;
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   // frame open from start to stop on the wire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
         in_frame_reg <= 1'b0;
      end else begin
         scl_prev_reg <= scl_in;
         sda_prev_reg <= sda_in;
         if (scl_prev_reg && scl_in && sda_prev_reg != sda_in) begin
            in_frame_reg <= sda_prev_reg;
         end
      end
   end
   // saturating age since reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         age_reg <= 4'h0;
      end else if (age_reg != 4'hF) begin
         age_reg <= age_reg + 4'h1;
      end
   end
   // ------------------
   // properties
   // ------------------
   property p_powerup_levels;
      $rose(presetn) |-> ##4 io_port_pins_oe ==
         ~{{4{port_pullup_en[7]}}, {4{port_pullup_en[3]}}};
   endproperty
   a_powerup_levels: assert property (p_powerup_levels)
      else $error("power-up port levels wrong");
   property p_pullup_groups;
      port_pullup_en[7:4] inside {4'h0, 4'hF} &&
         port_pullup_en[3:0] inside {4'h0, 4'hF};
   endproperty
   a_pullup_groups: assert property (p_pullup_groups)
      else $error("pullups not grouped");
   property p_reset_quiet;
      $rose(presetn) |-> !change_alert_n_oe && !irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("alert or irq active after reset");
   property p_alert_release;
      $fell(change_alert_n_oe) |-> sda_oe || $past(sda_oe);
   endproperty
   a_alert_release: assert property (p_alert_release)
      else $error("alert released off acknowledge");
   property p_change_alert;
      age_reg == 4'hF && !in_frame_reg && $changed(io_port_pins_in)
         |-> ##[1:8] change_alert_n_oe;
   endproperty
   a_change_alert: assert property (p_change_alert)
      else $error("port change raised no alert");
   property p_alert_latched;
      change_alert_n_oe && !in_frame_reg |=> change_alert_n_oe;
   endproperty
   a_alert_latched: assert property (p_alert_latched)
      else $error("alert dropped off frame");
   property p_class_at_stop;
      age_reg == 4'hF && $changed(port_pullup_en) |-> !in_frame_reg;
   endproperty
   a_class_at_stop: assert property (p_class_at_stop)
      else $error("pullups changed in frame");
   property p_alert_drive;
      change_alert_n_oe |-> change_alert_n_out == 1'b0;
   endproperty
   a_alert_drive: assert property (p_alert_drive)
      else $error("alert driven high");
endmodule // pxc_expander_chk

bind pxc_expander pxc_expander_chk u_pxc_expander_chk (
   .pclk, .presetn, .scl_in, .sda_in, .sda_oe, .io_port_pins_in,
   .io_port_pins_oe, .port_pullup_en, .change_alert_n_out,
   .change_alert_n_oe, .irq
);

// ===== verif/pxc_i2c_master.sv
// two-wire bus master model
`timescale 1ns/1ps
module pxc_i2c_master (
   // clock
   input wire logic pclk,
   // bus lines
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   // both lines released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // wait n clock edges
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one bit, 160 ns: set mid low, sample mid high
   task automatic bit_io(input logic b, output logic r);
      tick(4);
      sda_drv <= b;
      tick(4);
      scl <= 1'b1;
      tick(4);
      r = sda;
      tick(4);
      scl <= 1'b0;
   endtask
   // start condition
   task automatic start();
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b0;
   endtask
   // stop, then bus idles
   task automatic stop();
      tick(4);
      sda_drv <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(4);
      sda_drv <= 1'b1;
      tick(16);
   endtask
   // eight bits msb first, then ack
   task automatic xbyte(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(last, ack);
   endtask
endmodule // pxc_i2c_master

// ===== verif/tb_pxc_expander.sv
// bench for the port expander
`timescale 1ns/1ps
module tb_pxc_expander;
   import pxc_pkg::*;
   // ------------------
   // signals
   // ------------------
   logic pclk, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, d;
   logic pready, pslverr, irq, sda_oe, alert_oe, e, ack;
   logic scl, sda_drv, sda, hi_pin, lo_pin;
   logic [1:0] hi_cls = 2'h1, lo_cls = 2'h1, ph, pl;
   logic [7:0] ext = 8'hFF, pins, poe, pull, q;
   int num_errors = 0, num_checks = 0;
   // wired-and lines, straps by class
   assign sda = sda_drv & ~sda_oe;
   assign pins = ext & ~poe;
   assign hi_pin = hi_cls[1] ? (hi_cls[0] ? sda : scl) : hi_cls[0];
   assign lo_pin = lo_cls[1] ? (lo_cls[0] ? sda : scl) : lo_cls[0];
   // ------------------
   // design and bus master
   // ------------------
   pxc_expander u_pxc_expander (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .scl_in(scl),
      .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .addr_select_high_group(hi_pin), .addr_select_low_group(lo_pin),
      .io_port_pins_in(pins), .io_port_pins_out(), .io_port_pins_oe(poe),
      .port_pullup_en(pull), .change_alert_n_out(),
      .change_alert_n_oe(alert_oe)
   );
   pxc_i2c_master u_pxc_i2c_master (
      .pclk(pclk), .sda(sda), .scl(scl), .sda_drv(sda_drv)
   );
   // ------------------
   // tasks
   // ------------------
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, d, e);
      check(d, exp);
   endtask
   // address register image
   function automatic logic [31:0] exp_addr(input logic [1:0] h, l);
      return {8'h00, {4{h != 2'h0}}, {4{l != 2'h0}}, 4'h0, h, l, 1'b0,
              3'h6, h ^ 2'h2, l};
   endfunction
   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ------------------
   // clock, watchdog, tests
   // ------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #200_000;
      num_errors++;
      print_verdict();
   end
   initial begin
      // straps on supply only at power-up
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      rd_check(PXC_OFS_ADDR, exp_addr(2'h1, 2'h1));
      check(pull, 8'hFF);
      check(poe, 8'h00);
      check(alert_oe, 1'b0);
      rd_check(PXC_OFS_FLAGS, 32'h0);
      rd_check(PXC_OFS_CTRL, 32'h1);
      rd_check(PXC_OFS_MASK, 32'h0);
      rd_check(PXC_OFS_OUTPUT, 32'hFF);
      apb(1'b1, PXC_OFS_FLAGS, 32'hFF, d, e);
      rd_check(PXC_OFS_FLAGS, 32'h0);
      rd_check(8'h1C, 32'h0);
      check(e, 1'b1);
      // port change latches flag and alert
      apb(1'b1, PXC_OFS_MASK, 32'h1, d, e);
      ext <= 8'hFB;
      for (int i = 0; i < 20 && alert_oe !== 1'b1; i++) @(posedge pclk);
      check(alert_oe, 1'b1);
      check(irq, 1'b1);
      rd_check(PXC_OFS_FLAGS, 32'h4);
      rd_check(PXC_OFS_PORTS, 32'hFFFB);
      rd_check(PXC_OFS_STATUS, 32'h1);
      check(irq, 1'b0);
      // masked event keeps irq low
      apb(1'b1, PXC_OFS_MASK, 32'h0, d, e);
      ext <= 8'hF3;
      repeat (10) @(posedge pclk);
      check(irq, 1'b0);
      rd_check(PXC_OFS_STATUS, 32'h1);
      apb(1'b1, PXC_OFS_MASK, 32'h2, d, e);
      // two-byte read: ports, old flags
      u_pxc_i2c_master.start();
      u_pxc_i2c_master.xbyte(8'hDB, 1'b1, q, ack);
      check(ack, 1'b0);
      check(alert_oe, 1'b0);
      u_pxc_i2c_master.xbyte(8'hFF, 1'b0, q, ack);
      check(q, 8'hF3);
      u_pxc_i2c_master.xbyte(8'hFF, 1'b1, q, ack);
      check(q, 8'h0C);
      u_pxc_i2c_master.stop();
      rd_check(PXC_OFS_FLAGS, 32'h0);
      rd_check(PXC_OFS_PORTS, 32'hF3F3);
      check(alert_oe, 1'b0);
      check(irq, 1'b1);
      rd_check(PXC_OFS_STATUS, 32'h2);
      // each strap class, decoded at next frame
      ph = 2'h1;
      pl = 2'h1;
      for (int i = 0; i < 4; i++) begin
         hi_cls <= 2'(i);
         lo_cls <= 2'(3 - i);
         repeat (4) @(posedge pclk);
         rd_check(PXC_OFS_ADDR, exp_addr(ph, pl));
         u_pxc_i2c_master.start();
         u_pxc_i2c_master.xbyte(8'h40, 1'b1, q, ack);
         u_pxc_i2c_master.stop();
         check(ack, 1'b1);
         ph = 2'(i);
         pl = 2'(3 - i);
         rd_check(PXC_OFS_ADDR, exp_addr(ph, pl));
         check(pull, exp_addr(ph, pl) >> 16);
      end
      // write to new address drives ports
      u_pxc_i2c_master.start();
      u_pxc_i2c_master.xbyte(8'hC8, 1'b1, q, ack);
      check(ack, 1'b0);
      u_pxc_i2c_master.xbyte(8'h5A, 1'b1, q, ack);
      check(ack, 1'b0);
      u_pxc_i2c_master.stop();
      check(poe, 8'hA5);
      rd_check(PXC_OFS_OUTPUT, 32'h5A);
      // reset again, upper group grounded
      ext <= 8'h0F;
      hi_cls <= 2'h0;
      lo_cls <= 2'h1;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      check(poe, 8'hF0);
      check(pull, 8'h0F);
      rd_check(PXC_OFS_ADDR, exp_addr(2'h0, 2'h1));
      print_verdict();
   end
endmodule // tb_pxc_expander
